// >>> flash_poll_pkg.sv
package flash_poll_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_EXP = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam int CTRL_START = 0;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_RST_CMD = 2;
    localparam int CTRL_ABORT = 3;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_RDY = 3;
    localparam int ST_TGLB = 4;
    localparam int ST_DATA_LSB = 8;
    // ----------------------------------------
    // Status bit positions on the data bus
    // ----------------------------------------
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT_A = 6;
    localparam int TIME_LIMIT_FAIL_BIT = 5;
    localparam int TOGGLE_BIT_B = 2;
    localparam logic [7:0] RESET_CMD = 8'hF0;
    // ----------------------------------------
    // Bus cycle timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int STROBE_NS = 70;
    localparam int RECOVER_NS = 30;
    localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] RECOVER_CYC = 4'((RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [19:0] ADDR_RESET = 20'h0_0000;
    // ----------------------------------------
    // Sequencer states and check phases
    // ----------------------------------------
    typedef enum logic [2:0]
    {
        S_IDLE = 3'b000,
        S_RD = 3'b001,
        S_RGAP = 3'b011,
        S_EVAL = 3'b010,
        S_WR = 3'b110,
        S_WGAP = 3'b111
    } state_e;
    localparam logic [1:0] PH_FIRST = 2'd0;
    localparam logic [1:0] PH_CMP = 2'd1;
    localparam logic [1:0] PH_DATA = 2'd2;
    localparam logic [1:0] PH_RECHK = 2'd3;
endpackage : flash_poll_pkg

// >>> flash_poll_host.sv
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module flash_poll_host
    import flash_poll_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // Flash pins
    output logic [19:0] o_fl_addr,
    output logic o_fl_ce_n,
    output logic o_fl_oe_n,
    output logic o_fl_we_n,
    output logic [7:0] o_fl_dq_out,
    output logic o_fl_dq_oe_n,
    input wire logic [7:0] i_fl_dq,
    input wire logic i_fl_ready_busy_n
);
    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic wr_pend_q;
    logic [7:0] wr_off_q;
    logic mode_q;
    logic [19:0] addr_q;
    logic [7:0] exp_q;
    logic busy_q;
    logic done_q;
    logic fail_q;
    logic rdy_q;
    logic tglb_q;
    logic [7:0] last_q;
    wire addr_ok = i_hsel && i_htrans[1] && i_hready;
    wire [7:0] a_off = i_haddr[7:0];
    wire wr_ctrl = wr_pend_q && (wr_off_q == OFF_CTRL);
    wire start_req = wr_ctrl && i_hwdata[CTRL_START] && !busy_q;
    wire rst_req = wr_ctrl && i_hwdata[CTRL_RST_CMD] && !busy_q && !start_req;
    wire abort_req = wr_ctrl && i_hwdata[CTRL_ABORT] && busy_q;
    wire [31:0] status_w = {16'h0000, last_q, 3'b000, tglb_q, rdy_q, fail_q, done_q, busy_q};
    wire [31:0] rd_mux = (a_off == OFF_CTRL) ? {30'h0000_0000, mode_q, 1'b0} :
                         (a_off == OFF_ADDR) ? {12'h000, addr_q} :
                         (a_off == OFF_EXP) ? {24'h00_0000, exp_q} :
                         (a_off == OFF_STATUS) ? status_w : 32'h0000_0000;

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            wr_pend_q <= 1'b0;
            wr_off_q <= 8'h00;
            o_hrdata <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
        else
        begin
            wr_pend_q <= addr_ok && i_hwrite;
            wr_off_q <= a_off;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            if (addr_ok && !i_hwrite)
            begin
                o_hrdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            mode_q <= 1'b0;
            addr_q <= ADDR_RESET;
            exp_q <= 8'h00;
            rdy_q <= 1'b1;
        end
        else
        begin
            rdy_q <= i_fl_ready_busy_n;
            if (wr_ctrl && !busy_q)
            begin
                mode_q <= i_hwdata[CTRL_MODE];
            end
            if (wr_pend_q && (wr_off_q == OFF_ADDR) && !busy_q)
            begin
                addr_q <= i_hwdata[19:0];
            end
            if (wr_pend_q && (wr_off_q == OFF_EXP) && !busy_q)
            begin
                exp_q <= i_hwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // Status check sequencer
    // ----------------------------------------
    state_e state_q;
    logic [3:0] cnt_q;
    logic [1:0] phase_q;
    logic [7:0] prev_q;
    logic [7:0] smp_q;
    logic fail_pend_q;
    wire cnt_end = (cnt_q == 4'h1);
    wire tgl_same = (smp_q[TOGGLE_BIT_A] == prev_q[TOGGLE_BIT_A]);
    wire poll_true = (smp_q[POLL_BIT] == exp_q[POLL_BIT]);
    wire lim_hit = smp_q[TIME_LIMIT_FAIL_BIT];

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            state_q <= S_IDLE;
            cnt_q <= 4'h0;
            phase_q <= PH_FIRST;
            prev_q <= 8'h00;
            smp_q <= 8'h00;
            fail_pend_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            tglb_q <= 1'b0;
            last_q <= 8'h00;
            o_fl_addr <= ADDR_RESET;
            o_fl_ce_n <= 1'b1;
            o_fl_oe_n <= 1'b1;
            o_fl_we_n <= 1'b1;
            o_fl_dq_out <= 8'h00;
            o_fl_dq_oe_n <= 1'b1;
        end
        else if (abort_req)
        begin
            state_q <= S_IDLE;
            busy_q <= 1'b0;
            o_fl_ce_n <= 1'b1;
            o_fl_oe_n <= 1'b1;
            o_fl_we_n <= 1'b1;
            o_fl_dq_oe_n <= 1'b1;
        end
        else
        begin
            case (state_q)
                S_IDLE:
                begin
                    if (start_req)
                    begin
                        state_q <= S_RD;
                        phase_q <= PH_FIRST;
                        busy_q <= 1'b1;
                        done_q <= 1'b0;
                        fail_q <= 1'b0;
                        tglb_q <= 1'b0;
                        fail_pend_q <= 1'b0;
                        cnt_q <= STROBE_CYC;
                        o_fl_addr <= addr_q;
                        o_fl_ce_n <= 1'b0;
                        o_fl_oe_n <= 1'b0;
                    end
                    else if (rst_req)
                    begin
                        state_q <= S_WR;
                        busy_q <= 1'b1;
                        done_q <= 1'b0;
                        fail_pend_q <= 1'b0;
                        cnt_q <= STROBE_CYC;
                        o_fl_dq_out <= RESET_CMD;
                        o_fl_dq_oe_n <= 1'b0;
                        o_fl_ce_n <= 1'b0;
                        o_fl_we_n <= 1'b0;
                    end
                end
                S_RD:
                begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_end)
                    begin
                        smp_q <= i_fl_dq;
                        o_fl_oe_n <= 1'b1;
                        o_fl_ce_n <= 1'b1;
                        cnt_q <= RECOVER_CYC;
                        state_q <= S_RGAP;
                    end
                end
                S_RGAP:
                begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_end)
                    begin
                        state_q <= S_EVAL;
                    end
                end
                S_EVAL:
                begin
                    prev_q <= smp_q;
                    last_q <= smp_q;
                    state_q <= S_RD;
                    cnt_q <= STROBE_CYC;
                    o_fl_ce_n <= 1'b0;
                    o_fl_oe_n <= 1'b0;
                    if (phase_q != PH_FIRST && smp_q[TOGGLE_BIT_B] != prev_q[TOGGLE_BIT_B])
                    begin
                        tglb_q <= 1'b1;
                    end
                    if (phase_q == PH_DATA)
                    begin
                        state_q <= S_IDLE;
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        o_fl_ce_n <= 1'b1;
                        o_fl_oe_n <= 1'b1;
                    end
                    else if (mode_q)
                    begin
                        if (poll_true)
                        begin
                            phase_q <= PH_DATA;
                        end
                        else if (phase_q == PH_RECHK)
                        begin
                            fail_pend_q <= 1'b1;
                        end
                        else if (lim_hit)
                        begin
                            phase_q <= PH_RECHK;
                        end
                    end
                    else if (phase_q == PH_FIRST)
                    begin
                        phase_q <= PH_CMP;
                    end
                    else if (tgl_same)
                    begin
                        phase_q <= PH_DATA;
                    end
                    else if (phase_q == PH_RECHK)
                    begin
                        fail_pend_q <= 1'b1;
                    end
                    else if (lim_hit)
                    begin
                        phase_q <= PH_RECHK;
                    end
                    if ((phase_q == PH_RECHK) && !(mode_q ? poll_true : tgl_same))
                    begin
                        state_q <= S_WR;
                        fail_q <= 1'b1;
                        cnt_q <= STROBE_CYC;
                        o_fl_oe_n <= 1'b1;
                        o_fl_we_n <= 1'b0;
                        o_fl_dq_out <= RESET_CMD;
                        o_fl_dq_oe_n <= 1'b0;
                    end
                end
                S_WR:
                begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_end)
                    begin
                        o_fl_we_n <= 1'b1;
                        o_fl_ce_n <= 1'b1;
                        cnt_q <= RECOVER_CYC;
                        state_q <= S_WGAP;
                    end
                end
                S_WGAP:
                begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_end)
                    begin
                        o_fl_dq_oe_n <= 1'b1;
                        state_q <= S_IDLE;
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        fail_pend_q <= 1'b0;
                    end
                end
                default:
                begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule : flash_poll_host

// >>> flash_poll_chk.sv
`timescale 1ns/1ps
module flash_poll_chk
    import flash_poll_pkg::*;
(
    // Watched ports
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic [19:0] o_fl_addr,
    input wire logic o_fl_ce_n,
    input wire logic o_fl_oe_n,
    input wire logic o_fl_we_n,
    input wire logic [7:0] o_fl_dq_out,
    input wire logic o_fl_dq_oe_n
);
    // ----
    // Bus response and flash pin timing
    // ----
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    chk_bus_okay: assert property (o_hreadyout && !o_hresp)
        else $error("bus stalled or errored");
    chk_read_len: assert property ($fell(o_fl_oe_n) |-> (!o_fl_oe_n)[*7] ##1 o_fl_oe_n)
        else $error("read strobe length");
    chk_read_gap: assert property ($rose(o_fl_oe_n) |-> o_fl_oe_n[*3])
        else $error("read recovery short");
    chk_addr_hold: assert property (!o_fl_oe_n && !$fell(o_fl_oe_n) |-> $stable(o_fl_addr))
        else $error("address moved in read");
    chk_chip_sel: assert property (!o_fl_oe_n || !o_fl_we_n |-> !o_fl_ce_n)
        else $error("strobe without chip enable");
    chk_no_clash: assert property (!o_fl_dq_oe_n |-> o_fl_oe_n)
        else $error("data bus contention");
    chk_cmd_data: assert property (!o_fl_we_n |-> !o_fl_dq_oe_n && o_fl_dq_out == RESET_CMD)
        else $error("bad reset command data");
    chk_write_len: assert property ($fell(o_fl_we_n) |-> (!o_fl_we_n)[*7] ##1 o_fl_we_n)
        else $error("write strobe length");
    chk_data_hold: assert property ($rose(o_fl_we_n) |-> (!o_fl_dq_oe_n)[*2])
        else $error("write data not held");
endmodule : flash_poll_chk
bind flash_poll_host flash_poll_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .o_fl_addr(o_fl_addr), .o_fl_ce_n(o_fl_ce_n), .o_fl_oe_n(o_fl_oe_n),
    .o_fl_we_n(o_fl_we_n), .o_fl_dq_out(o_fl_dq_out), .o_fl_dq_oe_n(o_fl_dq_oe_n));

// >>> flash_dev_model.sv
`timescale 1ns/1ps
module flash_dev_model
    import flash_poll_pkg::*;
(
    // Flash pins
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic [7:0] i_dq,
    output logic [7:0] o_dq,
    output logic o_rb_pull
);
    // ----
    // Status encoding
    // ----
    logic busy = 0, fail = 0, pend = 0, tga = 0, tgb = 0, era = 0, susp = 0;
    logic [7:0] arr = 8'hFF, last = 8'h00, rdv, st;
    int cnt = 0, resets = 0;
    assign st = {susp | (!era & ~arr[7]), tga, fail, 2'b00, tgb, 2'b00};
    assign rdv = busy ? st : arr;
    assign o_dq = (!i_ce_n && !i_oe_n) ? rdv : ~last;
    assign o_rb_pull = busy && !susp;
    always @(posedge i_oe_n)
    begin
        last <= rdv;
        if (busy)
        begin
            tga <= tga ^ !susp;
            tgb <= tgb ^ (era | susp);
            if (cnt > 0) cnt <= cnt - 1;
            if (cnt == 1) {fail, busy} <= {pend, pend | susp};
        end
    end
    always @(posedge i_we_n)
        if (i_dq == RESET_CMD)
        begin
            {busy, fail, susp} <= 3'b000;
            resets <= resets + 1;
        end
    task launch(input int op, input int n, input int f, input logic [7:0] d);
        era = (op == 1);
        susp = (op == 2);
        pend = f[0];
        cnt = n;
        tga = 0;
        fail = 0;
        busy = 1;
        arr = era ? 8'hFF : d;
    endtask : launch
endmodule : flash_dev_model

// >>> tb.sv
`timescale 1ns/1ps
module tb;
    import flash_poll_pkg::*;
    // ----
    // Bench
    // ----
    logic clk, rst, hsel, hwrite, hready, hresp, ce_n, oe_n, we_n, dq_oe_n, rb_pull, rb;
    logic [31:0] haddr, hwdata, hrdata, rd, wa;
    logic [11:0] expq[$];
    logic [1:0] htrans;
    logic [19:0] fa;
    logic [7:0] dq_out, fdq, mdq;
    int fails = 0, compares = 0, cyc = 0, nres = 0;
    assign fdq = !dq_oe_n ? dq_out : mdq;
    assign rb = !rb_pull;
    flash_poll_host u_dut (.i_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .o_fl_addr(fa), .o_fl_ce_n(ce_n), .o_fl_oe_n(oe_n),
        .o_fl_we_n(we_n), .o_fl_dq_out(dq_out), .o_fl_dq_oe_n(dq_oe_n), .i_fl_dq(fdq),
        .i_fl_ready_busy_n(rb));
    flash_dev_model u_flash (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_dq(fdq), .o_dq(mdq),
        .o_rb_pull(rb_pull));
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            give_verdict();
        end
    end
    task give_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    task check(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : check
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge clk);
        while (!hready) @(posedge clk);
        hsel <= 0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (!hready) @(posedge clk);
        rd = hrdata;
    endtask : ahb
    task wait_done();
        repeat (300)
        begin
            ahb(0, OFF_STATUS, 0);
            if (rd[1] === 1'b1) break;
        end
    endtask : wait_done
    task run(input int op, input int n, input int f, input int md, input logic [7:0] d);
        logic [7:0] ed, mk;
        u_flash.launch(op, n, f, d);
        nres += f;
        ahb(1, OFF_EXP, {24'h0, (op == 0) ? d : 8'hFF});
        ahb(1, OFF_CTRL, 32'(md * 2 + 1));
        ahb(0, OFF_STATUS, 0);
        check(rd[3:0] & 4'h9, {op == 2, 3'b001}, "busy state");
        wait_done();
        ed = (op == 2) ? 8'h80 : (op == 1) ? 8'hFF : d;
        mk = f ? 8'h00 : (op == 2) ? 8'hFB : 8'hFF;
        expq.push_back({ed & mk, 1'b1, f[0], 2'b10});
        check({rd[15:8] & mk, rd[3:0]}, expq.pop_front(), "result");
        check(32'(fa), {12'h0, wa[19:0]}, "status address");
        if (op == 2)
            check(32'(rd[4]), 32'h1, "sector toggling seen");
        check(u_flash.resets, nres, "reset commands");
        $display("test op %0d mode %0d fail %0d ended", op, md, f);
    endtask : run
    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        rst = 1;
        rd = $urandom(96092);
        repeat (3) @(posedge clk);
        rst <= 0;
        ahb(0, OFF_ADDR, 0);
        check(rd, {12'h0, ADDR_RESET}, "addr reset");
        wa = 32'h000A_5A5A ^ $urandom;
        ahb(1, OFF_ADDR, wa);
        check(32'(fa), 32'h0, "addr idle");
        ahb(0, OFF_ADDR, 0);
        check(rd, {12'h0, wa[19:0]}, "addr readback");
        ahb(1, OFF_CTRL, 32'h0000_0002);
        ahb(0, OFF_CTRL, 0);
        check(rd, 32'h0000_0002, "mode readback");
        ahb(0, 8'h10, 0);
        check(rd, 32'h0000_0000, "unmapped read");
        $display("register test ended");
        u_flash.launch(0, 8, 0, 8'h3C);
        ahb(1, OFF_EXP, 32'h0000_003C);
        ahb(1, OFF_CTRL, 32'h0000_0001);
        repeat (7) @(posedge clk);
        ahb(1, OFF_CTRL, 32'h0000_0008);
        ahb(0, OFF_STATUS, 0);
        check(rd[2:0], 3'b000, "abort stops check");
        ahb(1, OFF_CTRL, 32'h0000_0001);
        wait_done();
        check({rd[15:8], rd[2:0]}, {8'h3C, 3'b010}, "restart result");
        $display("abort test ended");
        for (int i = 0; i < 12; i++)
            run(i % 3, 1 + $urandom % 8, int'(i == 3 || i == 7), (i / 3) % 2, 8'($urandom));
        nres++;
        ahb(1, OFF_CTRL, 32'h0000_0004);
        wait_done();
        check(u_flash.resets, nres, "reset command");
        check(rd[2:0], 3'b010, "reset command done");
        $display("reset test ended");
        give_verdict();
    end
endmodule : tb
